// ==== pport_pkg.sv ====
// constants for the bidirectional printer port
package pport_pkg;
  localparam logic [15:0] OPTION_SELECT_ADDR = 16'h0102;
  localparam int          OPT_MODE_BIT       = 7;
  localparam int          OPT_SET_HI_BIT     = 6;
  localparam int          OPT_SET_LO_BIT     = 5;
  localparam logic [15:0] SET1_DATA_ADDR     = 16'h03BC;
  localparam logic [15:0] SET2_DATA_ADDR     = 16'h0378;
  localparam logic [15:0] SET3_DATA_ADDR     = 16'h0278;
  localparam logic [1:0]  SET1_CODE          = 2'h0;
  localparam logic [1:0]  SET2_CODE          = 2'h1;
  localparam logic [1:0]  SET3_CODE          = 2'h2;
  localparam logic [15:0] STATUS_OFFSET      = 16'h0001;
  localparam logic [15:0] CONTROL_OFFSET     = 16'h0002;
  localparam int          CTL_DIR_BIT        = 5;
  localparam int          CTL_IRQ_EN_BIT     = 4;
  localparam int          CTL_SELECT_BIT     = 3;
  localparam int          CTL_RESTART_BIT    = 2;
  localparam int          CTL_FEED_BIT       = 1;
  localparam int          CTL_LOAD_BIT       = 0;
  localparam int          CTL_WIDTH          = 6;
  localparam logic [7:0]  DATA_RESET         = 8'h00;
  localparam logic [5:0]  CONTROL_RESET      = 6'h00;
  localparam logic        OPT_MODE_RESET     = 1'b1;
  localparam logic [1:0]  OPT_SET_RESET      = 2'h0;
  localparam logic [1:0]  STATUS_RSVD        = 2'h3;
endpackage

// ==== pport_sync.sv ====
// two flip-flop synchroniser for connector inputs
`timescale 1ns/1ps
module pport_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  // both stages reset to the idle pin level, so no false edge follows reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== pport_top.sv ====
// bidirectional printer port: data latch, pin status and line control
`timescale 1ns/1ps
module pport_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_hit,
  input  wire logic        setup_mode,
  input  wire logic        irq_ack,
  output logic             irq,
  input  wire logic [7:0]  port_data_lines_in,
  output logic      [7:0]  port_data_lines_out,
  output logic             port_data_lines_oe,
  input  wire logic        busy_in,
  input  wire logic        ack_b_in,
  input  wire logic        paper_out,
  input  wire logic        printer_online,
  input  wire logic        fault_b_in,
  output logic             load_pulse_b,
  output logic             line_feed_auto_b,
  output logic             restart_b,
  output logic             select_request_out_b
);
  // synchronised connector inputs
  logic [7:0] pins_s;
  logic [4:0] ctl_in_s;
  logic       busy_s;
  logic       ack_b_s;
  logic       paper_s;
  logic       online_s;
  logic       fault_b_s;

  pport_sync #(.WIDTH(8), .RESET_VAL(8'h00)) u_data_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (port_data_lines_in),
    .sync_out (pins_s)
  );

  // idle levels: not busy, acknowledge released, no fault
  pport_sync #(.WIDTH(5), .RESET_VAL(5'h09)) u_ctl_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({busy_in, ack_b_in, paper_out, printer_online, fault_b_in}),
    .sync_out (ctl_in_s)
  );

  assign busy_s    = ctl_in_s[4];
  assign ack_b_s   = ctl_in_s[3];
  assign paper_s   = ctl_in_s[2];
  assign online_s  = ctl_in_s[1];
  assign fault_b_s = ctl_in_s[0];

  // register state
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [5:0] ctl_q;
  logic [5:0] ctl_d;
  logic       ext_mode_q;
  logic       ext_mode_d;
  logic [1:0] addr_set_q;
  logic [1:0] addr_set_d;
  logic       pend_q;
  logic       pend_d;
  logic       ack_prev_q;
  logic       ack_prev_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // address decode
  logic [15:0] base_addr;
  logic        sel_data;
  logic        sel_status;
  logic        sel_ctl;
  logic        sel_option;
  logic        dir_read;
  logic        ack_rise;

  always_comb begin
    case (addr_set_q)
      pport_pkg::SET1_CODE: base_addr = pport_pkg::SET1_DATA_ADDR;
      pport_pkg::SET2_CODE: base_addr = pport_pkg::SET2_DATA_ADDR;
      pport_pkg::SET3_CODE: base_addr = pport_pkg::SET3_DATA_ADDR;
      default:              base_addr = pport_pkg::SET1_DATA_ADDR;
    endcase
  end

  assign sel_data   = (io_addr == base_addr);
  assign sel_status = (io_addr == 16'(base_addr + pport_pkg::STATUS_OFFSET));
  assign sel_ctl    = (io_addr == 16'(base_addr + pport_pkg::CONTROL_OFFSET));
  assign sel_option = setup_mode && (io_addr == pport_pkg::OPTION_SELECT_ADDR);
  assign io_hit     = sel_data | sel_status | sel_ctl;

  // direction only matters in extended mode; compatible always drives
  assign dir_read = ext_mode_q && ctl_q[pport_pkg::CTL_DIR_BIT];

  // acknowledge inactive is high; trailing edge is low to high
  assign ack_rise = ack_b_s && !ack_prev_q;

  always_comb begin
    data_d     = data_q;
    ctl_d      = ctl_q;
    ext_mode_d = ext_mode_q;
    addr_set_d = addr_set_q;
    pend_d     = pend_q;
    ack_prev_d = ack_b_s;
    rdata_d    = rdata_q;
    // write store is unconditional in both modes
    if (io_wr && sel_data) begin
      data_d = io_wdata;
    end
    if (io_wr && sel_ctl) begin
      ctl_d = io_wdata[pport_pkg::CTL_WIDTH-1:0];
    end
    // status writes fall through untouched
    if (io_wr && sel_option) begin
      ext_mode_d = ~io_wdata[pport_pkg::OPT_MODE_BIT];
      addr_set_d = io_wdata[pport_pkg::OPT_SET_HI_BIT:pport_pkg::OPT_SET_LO_BIT];
    end
    // a trailing edge in the same cycle as the clear keeps the flag set
    if (irq_ack) begin
      pend_d = 1'b0;
    end
    if (ack_rise && ctl_q[pport_pkg::CTL_IRQ_EN_BIT]) begin
      pend_d = 1'b1;
    end
    if (!ctl_q[pport_pkg::CTL_IRQ_EN_BIT]) begin
      pend_d = 1'b0;
    end
    if (io_rd) begin
      if (sel_data) begin
        rdata_d = dir_read ? pins_s : data_q;
      end else if (sel_status) begin
        rdata_d = {~busy_s, ack_b_s, paper_s, online_s, fault_b_s,
                   ~pend_q, pport_pkg::STATUS_RSVD};
      end else if (sel_ctl) begin
        rdata_d = {2'b00, 1'b0, ctl_q[pport_pkg::CTL_IRQ_EN_BIT:0]};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q     <= pport_pkg::DATA_RESET;
      ctl_q      <= pport_pkg::CONTROL_RESET;
      ext_mode_q <= ~pport_pkg::OPT_MODE_RESET;
      addr_set_q <= pport_pkg::OPT_SET_RESET;
      pend_q     <= 1'b0;
      ack_prev_q <= 1'b1;
      rdata_q    <= 8'h00;
    end else if (clk_en) begin
      data_q     <= data_d;
      ctl_q      <= ctl_d;
      ext_mode_q <= ext_mode_d;
      addr_set_q <= addr_set_d;
      pend_q     <= pend_d;
      ack_prev_q <= ack_prev_d;
      rdata_q    <= rdata_d;
    end
  end

  assign io_rdata = rdata_q;
  assign irq      = pend_q;

  // connector drive
  assign port_data_lines_out  = data_q;
  assign port_data_lines_oe   = !dir_read;
  assign select_request_out_b = ~ctl_q[pport_pkg::CTL_SELECT_BIT];
  assign restart_b            = ctl_q[pport_pkg::CTL_RESTART_BIT];
  assign line_feed_auto_b     = ~ctl_q[pport_pkg::CTL_FEED_BIT];
  assign load_pulse_b         = ~ctl_q[pport_pkg::CTL_LOAD_BIT];
endmodule

// ==== pport_assertions.sv ====
// pin-level assertions for the printer port
`timescale 1ns/1ps
module pport_assertions (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_hit,
  input wire logic        irq,
  input wire logic        ack_b_in,
  input wire logic [7:0]  port_data_lines_out,
  input wire logic        load_pulse_b,
  input wire logic        restart_b,
  input wire logic        select_request_out_b
);
  logic       wr_ok;
  logic       rd_ok;
  logic [1:0] sel;
  logic [4:0] ctl_d;
  logic [4:0] ctl_q;
  assign wr_ok = clk_en && io_wr && io_hit;
  assign rd_ok = clk_en && io_rd && io_hit;
  assign sel = io_addr[1:0];
  // shadow of the control bits, direction left out since it never reads back
  assign ctl_d = (wr_ok && sel == 2'h2) ? io_wdata[4:0] : ctl_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctl_q <= 5'h00;
    else ctl_q <= ctl_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_data_wr; wr_ok && sel == 2'h0 |=> port_data_lines_out == $past(io_wdata);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data latch");
  property p_ctl_out;
    {select_request_out_b, restart_b, load_pulse_b} == {~ctl_q[3], ctl_q[2], ~ctl_q[0]};
  endproperty
  a_ctl_out: assert property (p_ctl_out) else $error("control pins");
  property p_status_ro;
    wr_ok && sel == 2'h1 |=> $stable({port_data_lines_out, load_pulse_b, restart_b,
                                       select_request_out_b});
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write");
  property p_no_irq; clk_en && !ctl_q[4] |=> !irq; endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq disabled");
  property p_irq_set; $rose(ack_b_in) && ctl_q[4] |-> ##[1:4] irq; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq missing");
  property p_irq_flag; rd_ok && sel == 2'h1 |=> io_rdata[2] != $past(irq); endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("pending flag");
  property p_ctl_rd; rd_ok && sel == 2'h2 |=> io_rdata == {3'h0, $past(ctl_q)}; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
  property p_unmapped; clk_en && io_rd && !io_hit |=> io_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule

// ==== pport_printer_model.sv ====
// behavioural printer: takes a byte on each strobe and acknowledges it
`timescale 1ns/1ps
module pport_printer_model (
  input  wire logic       clk,
  input  wire logic       load_pulse_b,
  input  wire logic [7:0] port_data_lines_in,
  input  wire logic       slow,
  output logic            busy_in,
  output logic            ack_b_in,
  output logic [7:0]      got
);
  initial begin
    busy_in = 1'b0;
    ack_b_in = 1'b1;
    got = 8'h00;
  end
  // strobe low clocks the byte in; ack released ends the transfer
  always @(negedge load_pulse_b) begin
    got = port_data_lines_in;
    busy_in <= 1'b1;
    repeat (slow ? 9 : 2) @(posedge clk);
    ack_b_in <= 1'b0;
    repeat (2) @(posedge clk);
    busy_in <= 1'b0;
    ack_b_in <= 1'b1;
  end
endmodule

// ==== testbench.sv ====
// self-checking bench for the printer port
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, rst_b = 0, clk_en = 1, io_wr = 0, io_rd = 0, setup_mode = 0;
  logic        irq_ack = 0, paper_out = 0, printer_online = 1, fault_b_in = 1, slow = 0;
  logic        io_hit, irq, port_data_lines_oe, busy_in, ack_b_in, load_pulse_b;
  logic        line_feed_auto_b, restart_b, select_request_out_b;
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] base [3] = '{pport_pkg::SET2_DATA_ADDR, pport_pkg::SET3_DATA_ADDR,
                            pport_pkg::SET1_DATA_ADDR};
  logic [7:0]  io_wdata = 8'h00, offer = 8'h00, d, got, io_rdata, port_data_lines_out;
  logic [7:0]  port_data_lines_in;
  int          mismatches = 0, check_count = 0;
  always #20 clk = ~clk;
  // released lines show whatever the far side offers
  assign port_data_lines_in = port_data_lines_oe ? port_data_lines_out : offer;
  pport_top i_pport_top (.*);
  pport_printer_model i_pport_printer_model (.*);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= v;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clk);
    io_wr <= 0;
    io_rd <= 0;
    #1;
  endtask
  function automatic logic [7:0] stat(input logic pend);
    return {~busy_in, ack_b_in, paper_out, printer_online, fault_b_in, ~pend, 2'h3};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    d = 8'($urandom(65));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    acc(0, 16'h03BE, 0);
    chk(io_rdata, 8'h00);
    chk({restart_b, load_pulse_b, line_feed_auto_b, select_request_out_b,
         port_data_lines_oe, 3'h0}, 8'h78);
    $display("reset test done");
    repeat (6) begin
      d = 8'($urandom);
      acc(1, 16'h03BC, d);
      chk(port_data_lines_out, d);
      acc(1, 16'h03BE, {2'h0, d[5], 5'h06});
      chk({6'h0, line_feed_auto_b, port_data_lines_oe}, 8'h01);
      @(posedge clk);
      {paper_out, printer_online, fault_b_in} <= d[7:5];
      acc(1, 16'h03BD, ~d);
      acc(0, 16'h03BC, 0);
      chk(io_rdata, d);
      acc(0, 16'h03BD, 0);
      chk(io_rdata, stat(0));
    end
    $display("data test done");
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      slow <= i[0];
      acc(1, 16'h03BC, d);
      acc(1, 16'h03BE, {3'h0, !i[0], 4'h5});
      acc(1, 16'h03BE, {3'h0, !i[0], 4'h4});
      repeat (20) @(posedge clk);
      #1;
      chk(got, d);
      chk({7'h0, irq}, {7'h0, !i[0]});
      acc(0, 16'h03BD, 0);
      chk(io_rdata, stat(!i[0]));
      @(posedge clk);
      irq_ack <= 1;
      @(posedge clk);
      irq_ack <= 0;
      #1;
      chk({7'h0, irq}, 8'h00);
    end
    $display("strobe test done");
    @(posedge clk);
    setup_mode <= 1;
    acc(1, pport_pkg::OPTION_SELECT_ADDR, 8'h00);
    @(posedge clk);
    setup_mode <= 0;
    offer <= 8'($urandom);
    d = 8'($urandom);
    acc(1, 16'h03BE, 8'h24);
    acc(1, 16'h03BC, d);
    chk({7'h0, port_data_lines_oe}, 8'h00);
    acc(0, 16'h03BC, 0);
    chk(io_rdata, offer);
    acc(0, 16'h03BE, 0);
    chk(io_rdata, 8'h04);
    acc(1, 16'h03BE, 8'h04);
    acc(0, 16'h03BC, 0);
    chk(io_rdata, d);
    chk(port_data_lines_in, d);
    clk_en <= 0;
    acc(1, 16'h03BC, ~d);
    chk(port_data_lines_out, d);
    clk_en <= 1;
    $display("extended test done");
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      setup_mode <= 1;
      acc(1, pport_pkg::OPTION_SELECT_ADDR, {1'b0, 2'((s + 1) % 3), 5'h00});
      @(posedge clk);
      setup_mode <= 0;
      acc(1, base[s], d);
      acc(0, base[s], 0);
      chk(io_rdata, d);
      chk({7'h0, io_hit}, 8'h01);
      acc(0, base[(s + 2) % 3], 0);
      chk(io_rdata, 8'h00);
      chk({7'h0, io_hit}, 8'h00);
    end
    $display("address test done");
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    acc(0, 16'h03BE, 0);
    chk(io_rdata, 8'h00);
    chk({restart_b, load_pulse_b, line_feed_auto_b, select_request_out_b,
         port_data_lines_oe, 3'h0}, 8'h78);
    acc(0, 16'h03BD, 0);
    chk(io_rdata, stat(0));
    $display("second reset test done");
    complete_run();
  end
endmodule
bind pport_top pport_assertions i_pport_assertions (.*);
